// ===== common/jtbs_pkg.sv
package jtbs_pkg;

	// ----------------------------------------------------------------
	// sizes and instruction set
	// ----------------------------------------------------------------
	localparam int          IO_PINS    = 96;
	localparam int          IN_PINS    = 4;
	localparam int          MACROCELLS = 128;
	localparam int          CELL_CAPS  = 3;
	localparam int          IR_W       = 4;
	localparam int          ID_W       = 32;
	localparam logic [3:0]  OP_EXTEST  = 4'h0;
	localparam logic [3:0]  OP_SAMPLE  = 4'h1;
	localparam logic [3:0]  OP_IDCODE  = 4'h2;
	localparam logic [3:0]  OP_HIGHZ   = 4'h3;
	localparam logic [3:0]  OP_BYPASS  = 4'hf;
	localparam logic [3:0]  IR_CAPTURE = 4'h1;
	// arbitrary identity value, lsb fixed at one
	localparam logic [31:0] ID_VALUE   = 32'h0000_1001;

	// ----------------------------------------------------------------
	// controller states and pin group
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SH_IR, ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
	} jtbs_state_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic tdo;
	} jtbs_pin4_t;

endpackage

// ===== hdl/jtbs_io_cell.sv
// cell for an input or i/o pin: three capture stages, two update stages
module jtbs_io_cell
(
	input  wire logic i_tck,
	input  wire logic i_rst,
	input  wire logic i_capture,
	input  wire logic i_shift,
	input  wire logic i_update,
	input  wire logic i_si,
	input  wire logic i_pad_in,
	input  wire logic i_core_out,
	input  wire logic i_core_oe,
	output logic      o_so,
	output logic      o_upd_out,
	output logic      o_upd_oe
);
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic [2:0] cap_reg;

	// pad and core levels are foreign to the test clock
	always_ff @(posedge i_tck)
	begin
		meta_reg <= {i_core_oe, i_core_out, i_pad_in};
		sync_reg <= meta_reg;
	end

	// capture live levels or shift toward the test output
	always_ff @(posedge i_tck)
	begin
		if (i_capture)
			cap_reg <= sync_reg; // [RQ9] [RQ6]
		else if (i_shift)
			cap_reg <= {i_si, cap_reg[2:1]}; // [RQ8]
	end

	// update stages only move on the update pulse
	always_ff @(posedge i_tck)
	begin
		if (i_rst)
		begin
			o_upd_out <= 1'b0;
			o_upd_oe  <= 1'b0;
		end
		else if (i_update)
		begin
			o_upd_out <= cap_reg[1]; // [RQ9]
			o_upd_oe  <= cap_reg[2];
		end
	end

	assign o_so = cap_reg[0];

	property p_cell_cap;
		@(posedge i_tck) disable iff (i_rst)
		i_capture |=> cap_reg == $past(sync_reg);
	endproperty
	a_cell_cap: assert property (p_cell_cap) else $error("cell capture lost"); // [RQ9]
endmodule

// ===== hdl/jtbs_mc_cell.sv
// cell for a macrocell: three capture stages, one update stage
module jtbs_mc_cell
(
	input  wire logic i_tck,
	input  wire logic i_rst,
	input  wire logic i_capture,
	input  wire logic i_shift,
	input  wire logic i_update,
	input  wire logic i_si,
	input  wire logic i_mc_d,
	input  wire logic i_mc_q,
	input  wire logic i_mc_oe,
	output logic      o_so,
	output logic      o_upd_q
);
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic [2:0] cap_reg;

	// macrocell levels come from the system clock domain
	always_ff @(posedge i_tck)
	begin
		meta_reg <= {i_mc_oe, i_mc_q, i_mc_d};
		sync_reg <= meta_reg;
	end

	// capture or shift
	always_ff @(posedge i_tck)
	begin
		if (i_capture)
			cap_reg <= sync_reg; // [RQ9] [RQ7]
		else if (i_shift)
			cap_reg <= {i_si, cap_reg[2:1]}; // [RQ8]
	end

	// single update stage forces the macrocell output under extest
	always_ff @(posedge i_tck)
	begin
		if (i_rst)
			o_upd_q <= 1'b0;
		else if (i_update)
			o_upd_q <= cap_reg[1]; // [RQ9]
	end

	assign o_so = cap_reg[0];
endmodule

// ===== hdl/jtbs_test_port.sv
// Function
// RQ1: controller resets itself at power up
// RQ2: sample, extest, bypass, idcode, highz supported
// RQ3: every input and i/o pin has cell
// RQ4: port disabled means four pins are gpio
// RQ5: programming uses the same four pins
// RQ6: cell has three capture, two update stages
// RQ7: pin cells and macrocell cells differ
// RQ8: one chain from test input to output
// RQ9: capture samples, shifts and loads updates
// RQ10: controller generates all cell controls internally
// RQ11: four-bit opcodes, id value, one-bit bypass
module jtbs_test_port
#(
	parameter int N_IO = jtbs_pkg::IO_PINS,
	parameter int N_IN = jtbs_pkg::IN_PINS,
	parameter int N_MC = jtbs_pkg::MACROCELLS
)
(
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst,
	input  wire logic                 i_tck,
	input  wire logic                 i_cfg_jtag_en,
	input  wire jtbs_pkg::jtbs_pin4_t i_jp_in,
	output jtbs_pkg::jtbs_pin4_t      o_jp_out,
	output jtbs_pkg::jtbs_pin4_t      o_jp_oe,
	input  wire jtbs_pkg::jtbs_pin4_t i_gp_out,
	input  wire jtbs_pkg::jtbs_pin4_t i_gp_oe,
	output jtbs_pkg::jtbs_pin4_t      o_gp_in,
	output logic                      o_jtag_active,
	input  wire logic [N_IO+N_IN-1:0] i_pad_in,
	output logic [N_IO+N_IN-1:0]      o_pad_out,
	output logic [N_IO+N_IN-1:0]      o_pad_oe,
	input  wire logic [N_IO+N_IN-1:0] i_core_out,
	input  wire logic [N_IO+N_IN-1:0] i_core_oe,
	output logic [N_IO+N_IN-1:0]      o_core_in,
	input  wire logic [N_MC-1:0]      i_mc_d,
	input  wire logic [N_MC-1:0]      i_mc_q,
	input  wire logic [N_MC-1:0]      i_mc_oe,
	output logic [N_MC-1:0]           o_mc_q
);
	localparam int N_PIN = N_IO + N_IN;
	localparam int N_CELL = N_PIN + N_MC;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (N_IO < 1 || N_IO > jtbs_pkg::IO_PINS || N_IN < 0 || N_IN > jtbs_pkg::IN_PINS
		|| N_MC < 1)
	begin : g_bad_size
		$error("unsupported pin or macrocell count");
	end

	// ----------------------------------------------------------------
	// system domain: configuration strap and pin synchronisers
	// ----------------------------------------------------------------
	logic       cfg_meta_reg;
	logic       cfg_sync_reg;
	logic       cfg_done_reg;
	logic       jtag_en_reg;
	logic       rst_req_reg;
	logic [3:0] gp_meta_reg;
	logic [3:0] gp_sync_reg;
	logic [N_PIN-1:0] pad_meta_reg;
	logic [N_PIN-1:0] pad_sync_reg;

	// strap level synchronised before it is caught
	always_ff @(posedge i_clk_sys)
	begin
		cfg_meta_reg <= i_cfg_jtag_en;
		cfg_sync_reg <= cfg_meta_reg;
	end

	// option caught once after reset release, then frozen
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			cfg_done_reg <= 1'b0;
			jtag_en_reg  <= 1'b0;
		end
		else if (!cfg_done_reg)
		begin
			cfg_done_reg <= 1'b1;
			jtag_en_reg  <= cfg_sync_reg; // [RQ4]
		end
	end

	// power-up reset request held until the option is known and enables the port
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			rst_req_reg <= 1'b1;
		else
			rst_req_reg <= !cfg_done_reg || !jtag_en_reg; // [RQ1]
	end

	// gpio reads of the four port pins and pad reads for the core
	always_ff @(posedge i_clk_sys)
	begin
		gp_meta_reg  <= i_jp_in;
		gp_sync_reg  <= gp_meta_reg;
		pad_meta_reg <= i_pad_in;
		pad_sync_reg <= pad_meta_reg;
	end

	assign o_gp_in = gp_sync_reg;
	assign o_core_in = pad_sync_reg;
	assign o_jtag_active = jtag_en_reg;

	// ----------------------------------------------------------------
	// test clock domain: reset crossing and controller
	// ----------------------------------------------------------------
	logic                  rst_meta_reg;
	logic                  rst_tck;
	jtbs_pkg::jtbs_state_t state_reg;
	jtbs_pkg::jtbs_state_t state_next;
	logic                  tms;
	logic                  tdi;

	assign tms = i_jp_in.tms;
	assign tdi = i_jp_in.tdi;

	// no reset pin: the request from the system side forces reset
	always_ff @(posedge i_tck)
	begin
		rst_meta_reg <= rst_req_reg;
		rst_tck      <= rst_meta_reg; // [RQ1]
	end

	// standard sixteen-state walk steered by tms
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			jtbs_pkg::ST_RESET:    state_next = tms ? jtbs_pkg::ST_RESET : jtbs_pkg::ST_IDLE;
			jtbs_pkg::ST_IDLE:     state_next = tms ? jtbs_pkg::ST_SEL_DR : jtbs_pkg::ST_IDLE;
			jtbs_pkg::ST_SEL_DR:   state_next = tms ? jtbs_pkg::ST_SEL_IR : jtbs_pkg::ST_CAP_DR;
			jtbs_pkg::ST_CAP_DR:   state_next = tms ? jtbs_pkg::ST_EX1_DR : jtbs_pkg::ST_SH_DR;
			jtbs_pkg::ST_SH_DR:    state_next = tms ? jtbs_pkg::ST_EX1_DR : jtbs_pkg::ST_SH_DR;
			jtbs_pkg::ST_EX1_DR:   state_next = tms ? jtbs_pkg::ST_UPD_DR : jtbs_pkg::ST_PAUSE_DR;
			jtbs_pkg::ST_PAUSE_DR: state_next = tms ? jtbs_pkg::ST_EX2_DR : jtbs_pkg::ST_PAUSE_DR;
			jtbs_pkg::ST_EX2_DR:   state_next = tms ? jtbs_pkg::ST_UPD_DR : jtbs_pkg::ST_SH_DR;
			jtbs_pkg::ST_UPD_DR:   state_next = tms ? jtbs_pkg::ST_SEL_DR : jtbs_pkg::ST_IDLE;
			jtbs_pkg::ST_SEL_IR:   state_next = tms ? jtbs_pkg::ST_RESET : jtbs_pkg::ST_CAP_IR;
			jtbs_pkg::ST_CAP_IR:   state_next = tms ? jtbs_pkg::ST_EX1_IR : jtbs_pkg::ST_SH_IR;
			jtbs_pkg::ST_SH_IR:    state_next = tms ? jtbs_pkg::ST_EX1_IR : jtbs_pkg::ST_SH_IR;
			jtbs_pkg::ST_EX1_IR:   state_next = tms ? jtbs_pkg::ST_UPD_IR : jtbs_pkg::ST_PAUSE_IR;
			jtbs_pkg::ST_PAUSE_IR: state_next = tms ? jtbs_pkg::ST_EX2_IR : jtbs_pkg::ST_PAUSE_IR;
			jtbs_pkg::ST_EX2_IR:   state_next = tms ? jtbs_pkg::ST_UPD_IR : jtbs_pkg::ST_SH_IR;
			jtbs_pkg::ST_UPD_IR:   state_next = tms ? jtbs_pkg::ST_SEL_DR : jtbs_pkg::ST_IDLE;
			default:               state_next = jtbs_pkg::ST_RESET;
		endcase
	end

	// controller state, forced to reset while the request stands
	always_ff @(posedge i_tck)
	begin
		if (rst_tck)
			state_reg <= jtbs_pkg::ST_RESET; // [RQ1]
		else
			state_reg <= state_next;
	end

	// ----------------------------------------------------------------
	// instruction register and data register selection
	// ----------------------------------------------------------------
	logic [jtbs_pkg::IR_W-1:0] ir_sh_reg;
	logic [jtbs_pkg::IR_W-1:0] ir_reg;
	logic                      sel_bsr;
	logic                      sel_id;
	logic                      mode_ext;
	logic                      mode_hiz;

	// shift stage: fixed capture pattern, then serial load
	always_ff @(posedge i_tck)
	begin
		if (state_reg == jtbs_pkg::ST_CAP_IR)
			ir_sh_reg <= jtbs_pkg::IR_CAPTURE; // [RQ11]
		else if (state_reg == jtbs_pkg::ST_SH_IR)
			ir_sh_reg <= {tdi, ir_sh_reg[jtbs_pkg::IR_W-1:1]};
	end

	// active instruction; reset selects the identity register
	always_ff @(posedge i_tck)
	begin
		if (rst_tck || state_reg == jtbs_pkg::ST_RESET)
			ir_reg <= jtbs_pkg::OP_IDCODE; // [RQ11]
		else if (state_reg == jtbs_pkg::ST_UPD_IR)
			ir_reg <= ir_sh_reg;
	end

	// unknown opcodes fall back to the one-bit bypass path
	assign sel_bsr  = (ir_reg == jtbs_pkg::OP_EXTEST) || (ir_reg == jtbs_pkg::OP_SAMPLE); // [RQ2]
	assign sel_id   = (ir_reg == jtbs_pkg::OP_IDCODE);
	assign mode_ext = (ir_reg == jtbs_pkg::OP_EXTEST);
	assign mode_hiz = (ir_reg == jtbs_pkg::OP_HIGHZ);

	// ----------------------------------------------------------------
	// bypass, identity and boundary chain
	// ----------------------------------------------------------------
	logic                  byp_reg;
	logic [jtbs_pkg::ID_W-1:0] id_sh_reg;
	logic                  cap_bsr;
	logic                  sh_bsr;
	logic                  upd_bsr;
	logic [N_CELL:0]       chain;
	logic [N_PIN-1:0]      upd_out;
	logic [N_PIN-1:0]      upd_oe;
	logic [N_MC-1:0]       upd_q;

	// cell controls come only from the controller state and the active instruction
	assign cap_bsr = sel_bsr && (state_reg == jtbs_pkg::ST_CAP_DR); // [RQ10]
	assign sh_bsr  = sel_bsr && (state_reg == jtbs_pkg::ST_SH_DR); // [RQ10]
	assign upd_bsr = sel_bsr && (state_reg == jtbs_pkg::ST_UPD_DR); // [RQ10]

	// single bypass stage captures zero
	always_ff @(posedge i_tck)
	begin
		if (state_reg == jtbs_pkg::ST_CAP_DR)
			byp_reg <= 1'b0;
		else if (state_reg == jtbs_pkg::ST_SH_DR)
			byp_reg <= tdi; // [RQ2] [RQ11]
	end

	// identity register shifts lsb first
	always_ff @(posedge i_tck)
	begin
		if (sel_id && state_reg == jtbs_pkg::ST_CAP_DR)
			id_sh_reg <= jtbs_pkg::ID_VALUE; // [RQ2]
		else if (sel_id && state_reg == jtbs_pkg::ST_SH_DR)
			id_sh_reg <= {tdi, id_sh_reg[jtbs_pkg::ID_W-1:1]};
	end

	// chain runs from tdi through macrocells then pins to tdo
	assign chain[N_CELL] = tdi; // [RQ8]

	for (genvar m = 0; m < N_MC; m++)
	begin : g_mc
		jtbs_mc_cell u_cell
		(
			.i_tck     (i_tck),
			.i_rst     (rst_tck),
			.i_capture (cap_bsr),
			.i_shift   (sh_bsr),
			.i_update  (upd_bsr),
			.i_si      (chain[N_PIN+m+1]),
			.i_mc_d    (i_mc_d[m]),
			.i_mc_q    (i_mc_q[m]),
			.i_mc_oe   (i_mc_oe[m]),
			.o_so      (chain[N_PIN+m]),
			.o_upd_q   (upd_q[m])
		); // [RQ7]
	end

	// one cell per pin; the last N_IN pins are input-only
	for (genvar p = 0; p < N_PIN; p++)
	begin : g_pin
		jtbs_io_cell u_cell
		(
			.i_tck      (i_tck),
			.i_rst      (rst_tck),
			.i_capture  (cap_bsr),
			.i_shift    (sh_bsr),
			.i_update   (upd_bsr),
			.i_si       (chain[p+1]),
			.i_pad_in   (i_pad_in[p]),
			.i_core_out (i_core_out[p]),
			.i_core_oe  (i_core_oe[p]),
			.o_so       (chain[p]),
			.o_upd_out  (upd_out[p]),
			.o_upd_oe   (upd_oe[p])
		); // [RQ3] [RQ6]

		// pad drivers: extest from update stages, highz floats all
		assign o_pad_out[p] = mode_ext ? upd_out[p] : i_core_out[p]; // [RQ2]
		assign o_pad_oe[p]  = (p >= N_IO || mode_hiz) ? 1'b0 :
		                      (mode_ext ? upd_oe[p] : i_core_oe[p]); // [RQ2] [RQ3]
	end

	assign o_mc_q = mode_ext ? upd_q : i_mc_q;

	// ----------------------------------------------------------------
	// test output and pin sharing
	// ----------------------------------------------------------------
	logic tdo_bit;
	logic tdo_reg;
	logic tdo_oe_reg;

	always_comb
	begin
		if (state_reg == jtbs_pkg::ST_SH_IR)
			tdo_bit = ir_sh_reg[0];
		else if (sel_bsr)
			tdo_bit = chain[0]; // [RQ8]
		else if (sel_id)
			tdo_bit = id_sh_reg[0];
		else
			tdo_bit = byp_reg;
	end

	// falling edge launch gives the tester a full half period
	always_ff @(negedge i_tck)
	begin
		if (rst_tck)
		begin
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end
		else
		begin
			tdo_reg    <= tdo_bit;
			tdo_oe_reg <= (state_reg == jtbs_pkg::ST_SH_IR) ||
			              (state_reg == jtbs_pkg::ST_SH_DR);
		end
	end

	// same four pins carry test and programming, or plain gpio
	always_comb
	begin
		if (jtag_en_reg)
		begin
			o_jp_out     = '0; // [RQ5]
			o_jp_out.tdo = tdo_reg;
			o_jp_oe      = '0;
			o_jp_oe.tdo  = tdo_oe_reg;
		end
		else
		begin
			o_jp_out = i_gp_out; // [RQ4]
			o_jp_oe  = i_gp_oe;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_por_reset;
		@(posedge i_tck) rst_tck |=> state_reg == jtbs_pkg::ST_RESET;
	endproperty
	a_por_reset: assert property (p_por_reset) else $error("no reset state"); // [RQ1]

	property p_ir_default;
		@(posedge i_tck) disable iff (rst_tck)
		state_reg == jtbs_pkg::ST_RESET |=> ir_reg == jtbs_pkg::OP_IDCODE;
	endproperty
	a_ir_default: assert property (p_ir_default) else $error("idcode not default"); // [RQ11]

	property p_ir_capture;
		@(posedge i_tck) disable iff (rst_tck)
		state_reg == jtbs_pkg::ST_CAP_IR ##1 state_reg == jtbs_pkg::ST_SH_IR
		|=> ir_sh_reg == {$past(tdi), jtbs_pkg::IR_CAPTURE[3:1]};
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("ir capture wrong"); // [RQ11]

	property p_highz;
		@(posedge i_tck) disable iff (rst_tck)
		ir_reg == jtbs_pkg::OP_HIGHZ |-> o_pad_oe == '0;
	endproperty
	a_highz: assert property (p_highz) else $error("pad driven in highz"); // [RQ2]

	property p_bypass;
		@(posedge i_tck) disable iff (rst_tck)
		(state_reg == jtbs_pkg::ST_SH_DR && ir_reg == jtbs_pkg::OP_BYPASS)
		|=> byp_reg == $past(tdi);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass path broken"); // [RQ2]

	property p_idcode;
		@(posedge i_tck) disable iff (rst_tck)
		(state_reg == jtbs_pkg::ST_CAP_DR && sel_id) |=> id_sh_reg[0] && tdo_bit;
	endproperty
	a_idcode: assert property (p_idcode) else $error("id lsb not one"); // [RQ2]

	property p_tdo;
		@(posedge i_tck) disable iff (rst_tck)
		$past(state_reg) == jtbs_pkg::ST_SH_DR && state_reg == jtbs_pkg::ST_SH_DR
		|-> tdo_oe_reg && tdo_reg == tdo_bit;
	endproperty
	a_tdo: assert property (p_tdo) else $error("tdo not launched"); // [RQ8]

	property p_upd_pulse;
		@(posedge i_tck) disable iff (rst_tck)
		upd_bsr |=> !upd_bsr;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update not a pulse"); // [RQ10]

	property p_gpio;
		@(posedge i_clk_sys) disable iff (i_rst)
		!jtag_en_reg |-> o_jp_oe == i_gp_oe && o_jp_out == i_gp_out;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio pins not passed"); // [RQ4]
endmodule

// ===== test/jtbs_tester.sv
// ----------------------------------------------------------------
// far-side scan controller: makes tck only inside its tasks
// ----------------------------------------------------------------
module jtbs_tester
(
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi,
	input  wire logic i_tdo
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock stands low between frames
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end

	// one tck period; tdo is read in the low phase, before the rise
	task automatic tick(input logic tms, input logic tdi, output logic tdo_s);
		o_tms = tms;
		o_tdi = tdi;
		#62.5;
		tdo_s = i_tdo;
		o_tck = 1'b1;
		#62.5;
		o_tck = 1'b0;
	endtask

	// five or more ones reach reset whatever the state, then idle
	task automatic tlr();
		logic d;
		repeat (6) tick(1'b1, 1'b0, d);
		tick(1'b0, 1'b0, d);
	endtask

	// idle ticks first: the cells' synchronisers need tck edges
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic d;
		dout = '0;
		repeat (3) tick(1'b0, 1'b0, d);
		tick(1'b1, 1'b0, d);
		if (ir)
		begin
			tick(1'b1, 1'b0, d);
		end
		repeat (2) tick(1'b0, 1'b0, d);
		for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
		tick(1'b1, 1'b0, d);
		repeat (2) tick(1'b0, 1'b0, d);
	endtask
endmodule

// ===== test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// short chains: 4 i/o, 2 input-only, 2 macrocells
	// ----------------------------------------------------------------
	localparam int NO = 4;
	localparam int NI = 2;
	localparam int NM = 2;
	localparam int NP = NO + NI;
	localparam int CH = 3 * (NP + NM);
	localparam logic [3:0] OPS [0:3] = '{jtbs_pkg::OP_IDCODE, jtbs_pkg::OP_BYPASS,
		4'h7, jtbs_pkg::OP_HIGHZ};

	logic                 clk_sys  = 1'b0;
	logic                 rst      = 1'b1;
	logic                 cfg_en   = 1'b1;
	logic                 tck;
	logic                 tms;
	logic                 tdi;
	logic                 tdo_w;
	logic                 tdo_last = 1'b0;
	jtbs_pkg::jtbs_pin4_t jp_in;
	jtbs_pkg::jtbs_pin4_t jp_out;
	jtbs_pkg::jtbs_pin4_t jp_oe;
	jtbs_pkg::jtbs_pin4_t gp_out   = '0;
	jtbs_pkg::jtbs_pin4_t gp_oe    = '0;
	jtbs_pkg::jtbs_pin4_t gp_in;
	logic                 active;
	logic [NP-1:0]        pad_in   = '0;
	logic [NP-1:0]        pad_out;
	logic [NP-1:0]        pad_oe;
	logic [NP-1:0]        core_out = '0;
	logic [NP-1:0]        core_oe  = '0;
	logic [NP-1:0]        core_in;
	logic [NM-1:0]        mc_d     = '0;
	logic [NM-1:0]        mc_q     = '0;
	logic [NM-1:0]        mc_oe    = '0;
	logic [NM-1:0]        mc_q_out;
	logic [31:0]          v;
	logic [31:0]          p;
	logic [31:0]          d;
	int                   num_errors = 0;
	int                   n_tests    = 0;

	// system clock 100 ns
	always #50 clk_sys = ~clk_sys;

	// undriven tdo wire toggles, so a stale value never passes
	assign tdo_w = jp_oe.tdo ? jp_out.tdo : ~tdo_last;
	assign jp_in = {tck, tms, tdi, tdo_w};
	always @(negedge tck) tdo_last <= tdo_w;

	jtbs_test_port #(.N_IO(NO), .N_IN(NI), .N_MC(NM)) i_jtbs_test_port (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_tck(tck), .i_cfg_jtag_en(cfg_en),
		.i_jp_in(jp_in), .o_jp_out(jp_out), .o_jp_oe(jp_oe), .i_gp_out(gp_out),
		.i_gp_oe(gp_oe), .o_gp_in(gp_in), .o_jtag_active(active),
		.i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
		.i_core_out(core_out), .i_core_oe(core_oe), .o_core_in(core_in),
		.i_mc_d(mc_d), .i_mc_q(mc_q), .i_mc_oe(mc_oe), .o_mc_q(mc_q_out));

	jtbs_tester i_jtbs_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_w));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// chain order from tdo: pads (in, out, oe), then macrocells (d, q, oe)
	function automatic logic [31:0] exp_chain();
		logic [31:0] r;
		r = '0;
		for (int k = 0; k < NP; k++) r[3*k +: 3] = {core_oe[k], core_out[k], pad_in[k]};
		for (int m = 0; m < NM; m++) r[3*(NP+m) +: 3] = {mc_oe[m], mc_q[m], mc_d[m]};
		return r;
	endfunction

	// picks one stage of each cell out of a shifted-in pattern
	function automatic logic [31:0] upd(input logic [31:0] q, input int s, input int n);
		logic [31:0] r;
		r = '0;
		for (int k = 0; k < n; k++) r[k] = q[3*k + s];
		return r;
	endfunction

	task automatic stir();
		@(negedge clk_sys);
		pad_in = NP'($urandom);
		core_out = NP'($urandom);
		core_oe = NP'($urandom);
		mc_d = NM'($urandom);
		mc_q = NM'($urandom);
		mc_oe = NM'($urandom);
		gp_out = 4'($urandom);
		gp_oe = 4'($urandom);
	endtask

	task automatic chk_out(input logic ext, input logic [31:0] q);
		@(negedge clk_sys);
		if (ext)
		begin
			check(pad_out[NO-1:0], upd(q, 1, NO));
			check(pad_oe, upd(q, 2, NO));
			check(mc_q_out, upd(q >> (3*NP), 1, NM));
		end
		else
		begin
			check(pad_out, core_out);
			check(pad_oe, core_oe & NP'((1 << NO) - 1));
			check(mc_q_out, mc_q);
		end
	endtask

	task automatic do_reset(input logic en);
		@(negedge clk_sys);
		cfg_en = en;
		rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask

	// watchdog: the whole run needs well under a millisecond
	initial
	begin
		#3_000_000;
		num_errors++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(26187));
		// tck runs while the request stands: controller held in reset
		i_jtbs_tester.tlr();
		do_reset(1'b1);
		#13;
		i_jtbs_tester.tlr();
		check(active, 1'b1);
		check(jp_oe, 4'h0);
		i_jtbs_tester.scan(1'b0, 32, 32'h0, v);
		check(v, jtbs_pkg::ID_VALUE);
		$display("test power-up identity done");
		foreach (OPS[j])
		begin
			i_jtbs_tester.scan(1'b1, 4, {28'h0, OPS[j]}, v);
			check(v, 32'h1);
			d = $urandom;
			i_jtbs_tester.scan(1'b0, 32, d, v);
			check(v, (OPS[j] == jtbs_pkg::OP_IDCODE) ? jtbs_pkg::ID_VALUE : d << 1);
		end
		chk_out(1'b0, 32'h0);
		check(pad_oe, 32'h0);
		$display("test instruction table done");
		p = '0;
		for (int r = 0; r < 2; r++)
		begin
			i_jtbs_tester.scan(1'b1, 4, r[0] ? jtbs_pkg::OP_EXTEST : jtbs_pkg::OP_SAMPLE, v);
			check(v, 32'h1);
			chk_out(r[0], p);
			stir();
			// pad levels reach the core through two system flops
			repeat (2) @(negedge clk_sys);
			check(core_in, pad_in);
			p = $urandom & ((32'h1 << CH) - 1);
			i_jtbs_tester.scan(1'b0, CH, p, v);
			check(v, exp_chain());
			chk_out(r[0], p);
		end
		$display("test sample and extest done");
		i_jtbs_tester.tlr();
		chk_out(1'b0, 32'h0);
		i_jtbs_tester.scan(1'b0, 32, 32'h0, v);
		check(v, jtbs_pkg::ID_VALUE);
		$display("test reset by tms done");
		do_reset(1'b0);
		stir();
		check(active, 1'b0);
		repeat (3) @(negedge clk_sys);
		check(jp_out, gp_out);
		check(jp_oe, gp_oe);
		check(gp_in, jp_in);
		$display("test general purpose pins done");
		wrap_up();
	end
endmodule
